// file: aicc_adc_ctrl.v
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "aicc_map.vh"

// How it works
// RULE1: source codes 000,101-111 external; 001 bandgap; 011 protect; 010,100 ground.
// RULE2: software sets channel top bit whenever an internal source is chosen.
// RULE3: channel values 0-7 route that pin; top bit set leaves input floating.
// RULE4: reference code 01 picks supply; all other codes pick reference pin.
// RULE5: software enables reference pin function only for the pin reference.
// RULE6: conversion clock is system clock divided by two to the select.
// RULE7: software keeps conversion clock between 500 kHz and 1 MHz.
// RULE8: each set pin enable bit makes its pin an analog input.
// RULE9: set enable drops the pin's own function and its pull-high.
// RULE10: set enable overrides the port direction control.
// RULE11: start is a full low-high-low pulse on the start bit.
// RULE12: busy sets when a conversion starts, clears when it ends.
// RULE13: end of conversion sets request flag; interrupt when enabled.
// RULE14: with interrupt off, software polls busy until clear.
// RULE15: sixteen conversion clocks: four sampling then twelve converting.
// RULE16: result left aligned when format 0, right aligned when 1.
// RULE17: converter disabled keeps results unchanged and halts conversion.
// RULE18: start while busy restarts sampling and resets the prescaler.
module aicc_adc_ctrl (
	input  wire        clk,
	input  wire        rst_n,
	// wishbone classic slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [5:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output reg         wb_err_o,
	// pin side
	input  wire [7:0]  port_dir_in,
	input  wire [7:0]  port_pull_en,
	input  wire [11:0] analog_code,
	output reg  [7:0]  analog_pin_en,
	output reg  [7:0]  pin_dir_out,
	output reg  [7:0]  pin_pull_en,
	output reg  [7:0]  pin_digital_en,
	output reg  [7:0]  chan_route,
	output reg  [1:0]  route_kind,
	output reg         bandgap_sel,
	output reg         protect_sel,
	output reg         ref_supply_sel,
	output reg         converter_power,
	output reg         sample_hold,
	output reg         irq
);
	// --------------------------------------------------------
	// state and registers
	// --------------------------------------------------------
	localparam ST_IDLE   = 2'd0;
	localparam ST_SAMPLE = 2'd1;
	localparam ST_CONV   = 2'd2;

	reg [7:0]  start_chan_reg;
	reg [7:0]  src_ref_clk_reg;
	reg [7:0]  pin_en_reg;
	reg [7:0]  int_status_reg;
	reg [7:0]  int_mask_reg;
	reg [11:0] result_reg;
	reg [1:0]  state_reg;
	reg [4:0]  tick_cnt_reg;
	reg        start_armed_reg;

	wire       tick;
	wire [1:0] rt_kind;
	wire [7:0] rt_chan;
	wire       rt_bg;
	wire       rt_pr;
	wire       rt_ref;

	wire conv_en    = start_chan_reg[`AICC_CONV_EN_BIT];
	wire start_bit  = start_chan_reg[`AICC_START_BIT];
	wire fmt_right  = start_chan_reg[`AICC_FORMAT_BIT];
	wire busy       = (state_reg != ST_IDLE);
	wire bus_req    = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	// writes land at the ack edge, while the master still holds the cycle
	wire wr_lo      = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
		wb_sel_i[0];

	// --------------------------------------------------------
	// helpers
	// --------------------------------------------------------
	// result byte image for either alignment
	function [7:0] fmt_byte;
		input [11:0] res;
		input        right;
		input        high;
		begin
			if (right)
				fmt_byte = high ? {4'h0, res[11:8]} : res[7:0];
			else
				fmt_byte = high ? res[11:4] : {res[3:0], 4'h0};
		end
	endfunction // RULE16

	function known_addr;
		input [5:0] a;
		begin
			known_addr = (a == `AICC_ADDR_START_CHAN) ||
				(a == `AICC_ADDR_SRC_REF_CLK) ||
				(a == `AICC_ADDR_PIN_EN) ||
				(a == `AICC_ADDR_RES_HIGH) ||
				(a == `AICC_ADDR_RES_LOW) ||
				(a == `AICC_ADDR_INT_STATUS) ||
				(a == `AICC_ADDR_INT_MASK) ||
				(a == `AICC_ADDR_ANA_RESULT);
		end
	endfunction

	// --------------------------------------------------------
	// start pulse detection
	// --------------------------------------------------------
	// a conversion fires on the falling write of start, only after a
	// rising one was seen, so a lone clear does nothing
	wire start_wr   = wr_lo && (wb_adr_i == `AICC_ADDR_START_CHAN);
	wire start_new  = wb_dat_i[`AICC_START_BIT];
	wire start_fire = start_wr && start_bit && !start_new &&
		start_armed_reg && conv_en && wb_dat_i[`AICC_CONV_EN_BIT]; // RULE11

	always @(posedge clk) begin
		if (!rst_n)
			start_armed_reg <= 1'b0;
		else if (start_wr)
			start_armed_reg <= !start_bit && start_new; // RULE11
		else if (!conv_en)
			start_armed_reg <= 1'b0;
	end

	// --------------------------------------------------------
	// submodules
	// --------------------------------------------------------
	aicc_prescaler #(
		.CNT_W(7)
	) u_presc (
		.clk     (clk),
		.rst_n   (rst_n),
		.restart (start_fire || !busy),
		.div_sel (src_ref_clk_reg[`AICC_DIV_MSB:0]),
		.tick    (tick)
	); // RULE18

	aicc_input_route u_route (
		.clk             (clk),
		.rst_n           (rst_n),
		.src_sel         (src_ref_clk_reg[`AICC_SRC_MSB:`AICC_SRC_LSB]),
		.chan_sel        (start_chan_reg[`AICC_CHAN_MSB:0]),
		.ref_sel         (src_ref_clk_reg[`AICC_REF_MSB:`AICC_REF_LSB]),
		.route_kind      (rt_kind),
		.chan_onehot     (rt_chan),
		.int_bandgap_sel (rt_bg),
		.int_protect_sel (rt_pr),
		.ref_supply_sel  (rt_ref)
	);

	// --------------------------------------------------------
	// conversion sequencer
	// --------------------------------------------------------
	// count conversion-clock ticks; four sample then up to sixteen
	wire conv_done = (state_reg == ST_CONV) && tick &&
		(tick_cnt_reg == `AICC_TOTAL_CYCLES - 5'h01);

	always @(posedge clk) begin
		if (!rst_n) begin
			state_reg    <= ST_IDLE;
			tick_cnt_reg <= 5'h00;
			result_reg   <= 12'h000;
		end else if (!conv_en) begin
			state_reg    <= ST_IDLE; // RULE17
			tick_cnt_reg <= 5'h00;
		end else if (start_fire) begin
			state_reg    <= ST_SAMPLE; // RULE12 RULE18
			tick_cnt_reg <= 5'h00;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				tick_cnt_reg <= 5'h00;
			end
			ST_SAMPLE: begin
				if (tick) begin
					tick_cnt_reg <= tick_cnt_reg + 5'h01;
					if (tick_cnt_reg == `AICC_SAMPLE_CYCLES - 5'h01)
						state_reg <= ST_CONV; // RULE15
				end
			end
			ST_CONV: begin
				if (tick) begin
					tick_cnt_reg <= tick_cnt_reg + 5'h01;
					if (conv_done) begin
						state_reg  <= ST_IDLE; // RULE12 RULE15
						result_reg <= analog_code;
					end
				end
			end
			default: begin
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end

	// --------------------------------------------------------
	// register writes
	// --------------------------------------------------------
	// busy is reflected live on read, so the stored bit is written but never read back
	always @(posedge clk) begin
		if (!rst_n) begin
			start_chan_reg  <= `AICC_RESET_BYTE;
			src_ref_clk_reg <= `AICC_RESET_BYTE;
			pin_en_reg      <= `AICC_RESET_BYTE;
			int_mask_reg    <= `AICC_RESET_BYTE;
		end else if (wr_lo) begin
			case (wb_adr_i)
			`AICC_ADDR_START_CHAN:  start_chan_reg  <= wb_dat_i[7:0];
			`AICC_ADDR_SRC_REF_CLK: src_ref_clk_reg <= wb_dat_i[7:0];
			`AICC_ADDR_PIN_EN:      pin_en_reg      <= wb_dat_i[7:0];
			`AICC_ADDR_INT_MASK:    int_mask_reg    <= wb_dat_i[7:0];
			default: begin
			end
			endcase
		end
	end

	// --------------------------------------------------------
	// interrupt status
	// --------------------------------------------------------
	// bit 0 is end of conversion; a read clears it, but a completion
	// in the same cycle as the read wins so no event is lost
	wire stat_rd = bus_req && !wb_we_i &&
		(wb_adr_i == `AICC_ADDR_INT_STATUS);

	always @(posedge clk) begin
		if (!rst_n)
			int_status_reg <= `AICC_RESET_BYTE;
		else if (conv_done && conv_en)
			int_status_reg <= int_status_reg | 8'h01; // RULE13
		else if (stat_rd)
			int_status_reg <= `AICC_RESET_BYTE;
	end

	// --------------------------------------------------------
	// bus answer: one wait state, ack one cycle after request
	// --------------------------------------------------------
	always @(posedge clk) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= bus_req && known_addr(wb_adr_i);
			wb_err_o <= bus_req && !known_addr(wb_adr_i);
			wb_dat_o <= 32'h0000_0000;
			if (bus_req && !wb_we_i) begin
				case (wb_adr_i)
				`AICC_ADDR_START_CHAN:
					wb_dat_o[7:0] <= {start_chan_reg[7], busy,
						start_chan_reg[5:0]}; // RULE12
				`AICC_ADDR_SRC_REF_CLK: wb_dat_o[7:0] <= src_ref_clk_reg;
				`AICC_ADDR_PIN_EN:      wb_dat_o[7:0] <= pin_en_reg;
				`AICC_ADDR_RES_HIGH:
					wb_dat_o[7:0] <= fmt_byte(result_reg, fmt_right,
						1'b1); // RULE16
				`AICC_ADDR_RES_LOW:
					wb_dat_o[7:0] <= fmt_byte(result_reg, fmt_right,
						1'b0); // RULE16
				`AICC_ADDR_INT_STATUS:  wb_dat_o[7:0] <= int_status_reg;
				`AICC_ADDR_INT_MASK:    wb_dat_o[7:0] <= int_mask_reg;
				`AICC_ADDR_ANA_RESULT:  wb_dat_o[11:0] <= result_reg;
				default: begin
				end
				endcase
			end
		end
	end

	// --------------------------------------------------------
	// pin and analog outputs
	// --------------------------------------------------------
	// analog enable wins over direction, pull-high and digital path
	always @(posedge clk) begin
		if (!rst_n) begin
			analog_pin_en   <= 8'h00;
			pin_dir_out     <= 8'h00;
			pin_pull_en     <= 8'h00;
			pin_digital_en  <= 8'hFF;
			chan_route      <= 8'h00;
			route_kind      <= `AICC_ROUTE_NONE;
			bandgap_sel     <= 1'b0;
			protect_sel     <= 1'b0;
			ref_supply_sel  <= 1'b0;
			converter_power <= 1'b0;
			sample_hold     <= 1'b0;
			irq             <= 1'b0;
		end else begin
			analog_pin_en   <= pin_en_reg; // RULE8
			pin_dir_out     <= port_dir_in & ~pin_en_reg; // RULE10
			pin_pull_en     <= port_pull_en & ~pin_en_reg; // RULE9
			pin_digital_en  <= ~pin_en_reg; // RULE9
			chan_route      <= (rt_kind == `AICC_ROUTE_EXT) ?
				rt_chan : 8'h00; // RULE3
			route_kind      <= rt_kind;
			bandgap_sel     <= rt_bg; // RULE1
			protect_sel     <= rt_pr; // RULE1
			ref_supply_sel  <= rt_ref; // RULE4
			converter_power <= conv_en;
			sample_hold     <= (state_reg == ST_SAMPLE);
			irq             <= |(int_status_reg & int_mask_reg); // RULE13
		end
	end
endmodule

// file: aicc_map.vh
`ifndef AICC_MAP_VH
`define AICC_MAP_VH

// ------------------------------------------------------------
// register byte addresses (word aligned)
// ------------------------------------------------------------
`define AICC_ADDR_START_CHAN   6'h00
`define AICC_ADDR_SRC_REF_CLK  6'h04
`define AICC_ADDR_PIN_EN       6'h08
`define AICC_ADDR_RES_HIGH     6'h0C
`define AICC_ADDR_RES_LOW      6'h10
`define AICC_ADDR_INT_STATUS   6'h14
`define AICC_ADDR_INT_MASK     6'h18
`define AICC_ADDR_ANA_RESULT   6'h1C

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define AICC_START_BIT      7
`define AICC_BUSY_BIT       6
`define AICC_CONV_EN_BIT    5
`define AICC_FORMAT_BIT     4
`define AICC_CHAN_MSB       3
`define AICC_SRC_MSB        7
`define AICC_SRC_LSB        5
`define AICC_REF_MSB        4
`define AICC_REF_LSB        3
`define AICC_DIV_MSB        2

// ------------------------------------------------------------
// encodings, reset values, timing
// ------------------------------------------------------------
`define AICC_SRC_BANDGAP    3'h1
`define AICC_SRC_GND_A      3'h2
`define AICC_SRC_PROTECT    3'h3
`define AICC_SRC_GND_B      3'h4
`define AICC_REF_SUPPLY     2'h1
`define AICC_RESET_BYTE     8'h00
`define AICC_SAMPLE_CYCLES  5'h04
`define AICC_TOTAL_CYCLES   5'h10
`define AICC_ROUTE_NONE     2'h0
`define AICC_ROUTE_EXT      2'h1
`define AICC_ROUTE_INT      2'h2
`define AICC_ROUTE_GND      2'h3

`endif

// file: aicc_prescaler.v
`timescale 1ns/1ps
`include "aicc_map.vh"

// ------------------------------------------------------------
// conversion clock enable: one tick every 2**div_sel clocks
// ------------------------------------------------------------
module aicc_prescaler #(
	parameter CNT_W = 7
) (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       restart,
	input  wire [2:0] div_sel,
	output reg        tick
);
	reg [CNT_W-1:0] cnt_reg;
	wire [CNT_W-1:0] limit;

	// terminal count is 2**sel - 1; sel of zero ticks every clock
	assign limit = ({{(CNT_W-1){1'b0}}, 1'b1} << div_sel) - 1'b1;

	// restart clears the count so a new sample phase is full length
	always @(posedge clk) begin
		if (!rst_n || restart) begin
			cnt_reg <= {CNT_W{1'b0}};
			tick    <= 1'b0;
		end else if (cnt_reg >= limit) begin
			cnt_reg <= {CNT_W{1'b0}};
			tick    <= 1'b1; // RULE6
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
			tick    <= 1'b0;
		end
	end
endmodule

// file: aicc_input_route.v
`timescale 1ns/1ps
`include "aicc_map.vh"

// ------------------------------------------------------------
// source and reference decode, registered
// ------------------------------------------------------------
module aicc_input_route (
	input  wire       clk,
	input  wire       rst_n,
	input  wire [2:0] src_sel,
	input  wire [3:0] chan_sel,
	input  wire [1:0] ref_sel,
	output reg  [1:0] route_kind,
	output reg  [7:0] chan_onehot,
	output reg        int_bandgap_sel,
	output reg        int_protect_sel,
	output reg        ref_supply_sel
);
	reg       ext_src;
	reg [7:0] chan_dec;

	// external codes are everything but bandgap, protect and ground
	always @* begin
		ext_src  = !(src_sel == `AICC_SRC_BANDGAP ||
			src_sel == `AICC_SRC_PROTECT ||
			src_sel == `AICC_SRC_GND_A ||
			src_sel == `AICC_SRC_GND_B); // RULE1
		chan_dec = 8'h00;
		if (!chan_sel[`AICC_CHAN_MSB])
			chan_dec[chan_sel[2:0]] = 1'b1; // RULE3
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			route_kind      <= `AICC_ROUTE_EXT;
			chan_onehot     <= 8'h01;
			int_bandgap_sel <= 1'b0;
			int_protect_sel <= 1'b0;
			ref_supply_sel  <= 1'b0;
		end else begin
			// internal sources still decode a channel onto chan_onehot if software
			// leaves the channel top bit clear; the top level masks it off chan_route
			chan_onehot     <= chan_dec; // RULE3
			int_bandgap_sel <= (src_sel == `AICC_SRC_BANDGAP); // RULE1
			int_protect_sel <= (src_sel == `AICC_SRC_PROTECT); // RULE1
			ref_supply_sel  <= (ref_sel == `AICC_REF_SUPPLY); // RULE4
			if (ext_src)
				route_kind <= chan_sel[`AICC_CHAN_MSB] ?
					`AICC_ROUTE_NONE : `AICC_ROUTE_EXT; // RULE3
			else if (src_sel == `AICC_SRC_BANDGAP ||
				src_sel == `AICC_SRC_PROTECT)
				route_kind <= `AICC_ROUTE_INT;
			else
				route_kind <= `AICC_ROUTE_GND; // RULE1
		end
	end
endmodule

// file: aicc_assertions.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// port checker for the converter control block
// ------------------------------------------------------------
module aicc_checker (
	input wire		clk,
	input wire		rst_n,
	input wire		wb_cyc_i,
	input wire		wb_stb_i,
	input wire [31:0]	wb_dat_o,
	input wire		wb_ack_o,
	input wire		wb_err_o,
	input wire [7:0]	port_dir_in,
	input wire [7:0]	port_pull_en,
	input wire [7:0]	analog_pin_en,
	input wire [7:0]	pin_dir_out,
	input wire [7:0]	pin_pull_en,
	input wire [7:0]	pin_digital_en,
	input wire [7:0]	chan_route,
	input wire [1:0]	route_kind,
	input wire		bandgap_sel,
	input wire		protect_sel,
	input wire		converter_power,
	input wire		sample_hold
);
	// one clock domain, so one default for all
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// bus answers: one pulse per request, data only beside ack
	chk_ack_pulse:
		assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held past one cycle");
	chk_ack_answer:
		assert property ($rose(wb_stb_i) && wb_cyc_i |=> wb_ack_o ^ wb_err_o)
		else $error("request not answered next cycle");
	chk_dat_idle:
		assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside ack");
	// enabled pins leave the port logic; both outputs share one lag
	chk_pin_split:
		assert property (pin_digital_en == ~analog_pin_en)
		else $error("digital enable not inverse of pin enable");
	chk_pull_drop:
		assert property ($past(rst_n) |->
			pin_pull_en == ($past(port_pull_en) & ~analog_pin_en))
		else $error("pull-high kept on analog pin");
	chk_dir_override:
		assert property ($past(rst_n) |->
			pin_dir_out == ($past(port_dir_in) & ~analog_pin_en))
		else $error("port direction not overridden");
	// routing outputs must agree with each other
	chk_route_ext:
		assert property (chan_route != 8'h00 |->
			route_kind == 2'h1 && $onehot(chan_route))
		else $error("channel routed without external source");
	chk_int_source:
		assert property (bandgap_sel || protect_sel |->
			route_kind == 2'h2 && !(bandgap_sel && protect_sel))
		else $error("internal source select inconsistent");
	// sampling is never shorter than four clocks unless powered down
	chk_sample_len:
		assert property ($rose(sample_hold) |->
			(sample_hold || !converter_power)[*4])
		else $error("sampling phase too short");
endmodule

bind aicc_adc_ctrl aicc_checker chk_u (
	.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.port_dir_in(port_dir_in), .port_pull_en(port_pull_en),
	.analog_pin_en(analog_pin_en), .pin_dir_out(pin_dir_out),
	.pin_pull_en(pin_pull_en), .pin_digital_en(pin_digital_en),
	.chan_route(chan_route), .route_kind(route_kind),
	.bandgap_sel(bandgap_sel), .protect_sel(protect_sel),
	.converter_power(converter_power), .sample_hold(sample_hold)
);

// file: aicc_analog_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// analog side: port logic requests and the converted level
// ------------------------------------------------------------
module aicc_analog_model #(
	parameter [7:0]	DIR_BITS = 8'hFF,
	parameter [7:0]	PULL_BITS = 8'hF0
) (
	input wire		clk,
	input wire [7:0]	chan_route,
	input wire [1:0]	route_kind,
	output logic [7:0]	port_dir_in,
	output logic [7:0]	port_pull_en,
	output logic [11:0]	analog_code
);
	// port logic asks for outputs and pull-highs regardless of mode
	assign port_dir_in = DIR_BITS;
	assign port_pull_en = PULL_BITS;

	initial analog_code = 12'h0AA;

	// level per routed source; a floating input never settles
	always @(posedge clk) begin
		if (chan_route != 8'h00)
			analog_code <= {4'h5, chan_route};
		else if (route_kind[1])
			analog_code <= {route_kind, 10'h000};
		else
			analog_code <= ~analog_code;
	end
endmodule

// file: tb_top.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// testbench for the converter control block
// ------------------------------------------------------------
module tb_top;
	logic		clk;
	logic		rst_n;
	logic		cyc;
	logic		stb;
	logic		we;
	logic [5:0]	adr;
	logic [31:0]	wdat;
	logic [31:0]	rdat;
	logic		e;
	wire [31:0]	dat_o;
	wire		ack, err, irq, sh, pw, bg, pr, rs;
	wire [7:0]	dir_i, pull_i, ape, dir_o, pull_o, dig, route;
	wire [1:0]	kind;
	wire [11:0]	code;
	int		failures;
	int		comparisons;

	// block and the analog side it faces
	aicc_adc_ctrl dut_u (
		.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
		.port_dir_in(dir_i), .port_pull_en(pull_i), .analog_code(code),
		.analog_pin_en(ape), .pin_dir_out(dir_o), .pin_pull_en(pull_o),
		.pin_digital_en(dig), .chan_route(route), .route_kind(kind),
		.bandgap_sel(bg), .protect_sel(pr), .ref_supply_sel(rs),
		.converter_power(pw), .sample_hold(sh), .irq(irq)
	);
	aicc_analog_model far_u (
		.clk(clk), .chan_route(route), .route_kind(kind),
		.port_dir_in(dir_i), .port_pull_en(pull_i), .analog_code(code)
	);

	// 25 MHz system clock
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end

	task automatic chk(input string n, input logic [31:0] x,
		input logic [31:0] g);
		comparisons++;
		if (g !== x) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, x, g);
		end
	endtask

	task automatic rng(input string n, input int lo, input int hi,
		input int g);
		comparisons++;
		if (g < lo || g > hi) begin
			failures++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", n, lo, hi, g);
		end
	endtask

	// one classic cycle; request held until ack or err is sampled
	task automatic bus(input logic w, input logic [5:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= {24'h00_0000, d};
		@(posedge clk);
		while (ack !== 1'b1 && err !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		rdat = dat_o;
		e = err;
		cyc <= 0;
		stb <= 0;
		we <= 0;
		rng("bus_wait", 0, 39, n);
	endtask

	// a start pulse is two writes: start high, then start low
	task automatic pulse(input logic [7:0] c);
		bus(1, 6'h00, c | 8'hA0);
		bus(1, 6'h00, c | 8'h20);
	endtask

	task automatic wait_irq(output int n, output int h);
		n = 0;
		h = 0;
		while (irq !== 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
			h = h + sh;
		end
	endtask

	task automatic t_reset;
		for (int i = 0; i < 8; i++) begin
			bus(0, 6'(i * 4), 8'h00);
			chk("reset_reg", 0, rdat);
		end
		chk("reset_digital", 8'hFF, dig);
		bus(0, 6'h20, 8'h00);
		chk("unmapped_err", 1, e);
	endtask

	task automatic t_pins;
		bus(1, 6'h08, 8'hA5);
		repeat (2) @(posedge clk);
		chk("pin_en", 8'hA5, ape);
		chk("digital_en", 8'h5A, dig);
		chk("pull_en", 8'h50, pull_o);
		chk("dir_out", 8'h5A, dir_o);
		bus(0, 6'h08, 8'h00);
		chk("pin_readback", 8'hA5, rdat);
		bus(1, 6'h08, 8'h18);
	endtask

	// every source code, each with one reference code
	task automatic t_route;
		logic [1:0] kx[8] = '{1, 2, 3, 2, 3, 1, 1, 1};
		for (int s = 0; s < 8; s++) begin
			bus(1, 6'h00, kx[s] == 1 ? 8'h03 : 8'h08);
			bus(1, 6'h04, {s[2:0], s[1:0], 3'h0});
			repeat (3) @(posedge clk);
			chk("route_kind", kx[s], kind);
			chk("chan_route", kx[s] == 1 ? 8'h08 : 8'h00, route);
			chk("bandgap", s == 1, bg);
			chk("protect", s == 3, pr);
			chk("ref_supply", s[1:0] == 1, rs);
		end
		bus(1, 6'h00, 8'h08);
		repeat (3) @(posedge clk);
		chk("floating", 0, kind);
	endtask

	// every divider code, alternating result format
	task automatic t_conv;
		int n, h;
		logic [15:0] x;
		bus(1, 6'h18, 8'h01);
		for (int d = 0; d < 8; d++) begin
			bus(1, 6'h04, {5'h00, d[2:0]});
			pulse({3'h0, d[0], 4'h3});
			wait_irq(n, h);
			rng("conv_clocks", 16 << d, (16 << d) + 4, n);
			rng("sample_clocks", (4 << d) - 1, (4 << d) + 2, h);
			x = d[0] ? {4'h0, 12'h508} : {12'h508, 4'h0};
			bus(0, 6'h0C, 8'h00);
			chk("res_high", x[15:8], rdat);
			bus(0, 6'h10, 8'h00);
			chk("res_low", x[7:0], rdat);
			bus(0, 6'h14, 8'h00);
			chk("status", 1, rdat);
			repeat (2) @(posedge clk);
			chk("irq_cleared", 0, irq);
		end
	endtask

	// masked completion found by polling busy, then unmasked
	task automatic t_mask;
		int n;
		bus(1, 6'h18, 8'h00);
		bus(1, 6'h00, 8'h63);
		bus(0, 6'h00, 8'h00);
		chk("busy_read_only", 8'h23, rdat);
		bus(1, 6'h04, 8'h05);
		pulse(8'h03);
		bus(0, 6'h00, 8'h00);
		chk("busy_set", 1, rdat[6]);
		n = 0;
		while (rdat[6] !== 1'b0 && n < 400) begin
			bus(0, 6'h00, 8'h00);
			n++;
		end
		chk("busy_clear", 0, rdat[6]);
		chk("irq_masked", 0, irq);
		bus(1, 6'h18, 8'h01);
		repeat (2) @(posedge clk);
		chk("irq_level", 1, irq);
		bus(0, 6'h14, 8'h00);
		repeat (2) @(posedge clk);
		chk("irq_read_clear", 0, irq);
	endtask

	// restart while busy, then power down during the sampling phase
	task automatic t_restart;
		int n, h;
		bus(1, 6'h04, 8'h02);
		pulse(8'h03);
		repeat (20) @(posedge clk);
		pulse(8'h03);
		wait_irq(n, h);
		rng("restart_clocks", 64, 68, n);
		bus(0, 6'h14, 8'h00);
		pulse(8'h04);
		repeat (10) @(posedge clk);
		bus(1, 6'h00, 8'h04);
		repeat (100) @(posedge clk);
		chk("abort_irq", 0, irq);
		chk("power_off", 0, pw);
		bus(0, 6'h1C, 8'h00);
		chk("result_kept", 12'h508, rdat);
	endtask

	task automatic results;
		if (failures == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// main sequence: six reset cycles, then the scenarios
	initial begin
		cyc = 0;
		stb = 0;
		we = 0;
		adr = 6'h00;
		wdat = 32'h0000_0000;
		rst_n = 0;
		failures = 0;
		comparisons = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1;
		t_reset;
		t_pins;
		t_route;
		t_conv;
		t_mask;
		t_restart;
		results;
	end

	// watchdog well beyond the expected run length
	initial begin
		repeat (60000) @(posedge clk);
		failures++;
		results;
	end
endmodule
